// ---- iop_pkg.sv ----
package iop_pkg;

	typedef logic [31:0] iop_word_t;

	localparam int              IOP_NPORT = 5;
	localparam int              IOP_NCLK  = 6;
	localparam int              IOP_NPIN  = 32;
	localparam int              IOP_CNT_W = 16;
	localparam int              IOP_DIV_W = 8;

	// Port widths, narrowest first; index order is also pin priority
	localparam int              IOP_PORT_W [IOP_NPORT] = '{1, 4, 8, 16, 32};

	// Pins that the serial link takes over when enabled
	localparam iop_word_t       IOP_LINK_PINS = 32'hFF00_0000;

	// Address map (byte addresses, one word per register)
	localparam logic [11:0]     IOP_PORT_BASE   = 12'h000;
	localparam logic [11:0]     IOP_PORT_STRIDE = 12'h020;
	localparam logic [4:0]      IOP_OFS_CTRL    = 5'h00;
	localparam logic [4:0]      IOP_OFS_DATA    = 5'h04;
	localparam logic [4:0]      IOP_OFS_COND    = 5'h08;
	localparam logic [4:0]      IOP_OFS_TIME    = 5'h0C;
	localparam logic [4:0]      IOP_OFS_COUNT   = 5'h10;
	localparam logic [4:0]      IOP_OFS_TSTAMP  = 5'h14;
	localparam logic [4:0]      IOP_OFS_STAT    = 5'h18;
	localparam logic [11:0]     IOP_LINK_EN     = 12'h100;
	localparam logic [11:0]     IOP_IRQ_STAT    = 12'h104;
	localparam logic [11:0]     IOP_IRQ_MASK    = 12'h108;
	localparam logic [11:0]     IOP_CLK_BASE    = 12'h120;

	// Port control fields
	localparam int              IOP_CTL_EN      = 0;
	localparam int              IOP_CTL_OUT     = 1;
	localparam int              IOP_CTL_OC      = 2;
	localparam int              IOP_CTL_COND    = 3;
	localparam int              IOP_CTL_NEQ     = 4;
	localparam int              IOP_CTL_TIMED   = 5;
	localparam int              IOP_CTL_STB     = 6;
	localparam int              IOP_CTL_CLK_LSB = 8;

	// Clock block configuration fields
	localparam int              IOP_CK_EXT      = 0;
	localparam int              IOP_CK_DIV_LSB  = 8;

	// Reset values, and the word read at an unmapped address
	localparam iop_word_t       IOP_CTRL_RST    = 32'h0000_0000;
	localparam iop_word_t       IOP_CLKCFG_RST  = 32'h0000_0000;
	localparam iop_word_t       IOP_MASK_RST    = 32'h0000_0000;
	localparam iop_word_t       IOP_UNMAPPED    = 32'h0000_0000;

	typedef struct packed {
		logic                   en;
		logic                   out;
		logic                   oc;
		logic                   cond;
		logic                   cond_neq;
		logic                   timed;
		logic                   stb;
		logic [2:0]             clk_sel;
		iop_word_t              cond_val;
		logic [IOP_CNT_W-1:0]   time_val;
	} iop_port_cfg_s;

	typedef struct packed {
		iop_word_t              pin_word;
		iop_word_t              xfer;
		logic [IOP_CNT_W-1:0]   count;
		logic [IOP_CNT_W-1:0]   tstamp;
		logic                   valid;
		logic                   pending;
		logic                   ready;
		logic                   strobe;
	} iop_port_st_s;

endpackage

// ---- iop_clk_blk.sv ----
`timescale 1ns/1ps
module iop_clk_blk
	import iop_pkg::*;
(
	input  wire logic                   core_clk, // Core clock
	input  wire logic                   rst_n,    // Synchronous reset, active low
	input  wire logic                   ext_sel,  // Take edges from the 1-bit port pin
	input  wire logic [IOP_DIV_W-1:0]   div,      // Source edges per tick, minus one
	input  wire logic                   ext_lvl,  // Synchronised 1-bit port pin level
	output logic                        tick      // One-cycle active edge of this block
);

	logic                   ext_prev_ff;
	logic [IOP_DIV_W-1:0]   div_cnt_ff;
	logic                   src_edge;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			ext_prev_ff <= 1'b0;
		else
			ext_prev_ff <= ext_lvl;
	end

	// The reference source gives an edge every core cycle
	assign src_edge = ext_sel ? (ext_lvl & ~ext_prev_ff) : 1'b1;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			div_cnt_ff <= '0;
			tick       <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (src_edge)
			begin
				if (div_cnt_ff >= div)
				begin
					div_cnt_ff <= '0;
					tick       <= 1'b1;
				end
				else
					div_cnt_ff <= div_cnt_ff + 1'b1;
			end
		end
	end

endmodule

// ---- iop_port_unit.sv ----
`timescale 1ns/1ps
module iop_port_unit
	import iop_pkg::*;
(
	input  wire logic           core_clk,  // Core clock
	input  wire logic           rst_n,     // Synchronous reset, active low
	input  iop_port_cfg_s       cfg,       // Port configuration
	input  iop_word_t           wmask,     // Ones over the port's nominal width
	input  wire logic           tick,      // Active edge of the attached clock block
	input  iop_word_t           pins,      // Synchronised pin values
	input  wire logic           stb_in,    // Synchronised input strobe
	input  wire logic           wr_data,   // Core writes the transfer register
	input  iop_word_t           wdata,     // Word written by the core
	input  wire logic           rd_data,   // Core reads the transfer register
	output iop_port_st_s        st         // Port state
);

	logic   time_ok;
	logic   cond_ok;
	logic   in_go;
	logic   out_go;

	// Full nominal width always moves, shared pins or not
	assign time_ok = ~cfg.timed | (st.count == cfg.time_val);
	assign cond_ok = ~cfg.cond |
		(cfg.cond_neq ? ((pins & wmask) != (cfg.cond_val & wmask))
		              : ((pins & wmask) == (cfg.cond_val & wmask)));
	assign in_go   = cfg.en & ~cfg.out & tick & time_ok & cond_ok &
		(~cfg.stb | stb_in);
	assign out_go  = cfg.en & cfg.out & tick & time_ok & st.pending;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			st.count <= '0;
		else if (tick)
			st.count <= st.count + 1'b1;
	end

	// Transfer register on the core side, pin register on the pin side
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st.xfer     <= '0;
			st.pin_word <= '0;
		end
		else
		begin
			if (wr_data)
				st.xfer <= wdata & wmask;
			else if (in_go)
				st.xfer <= pins & wmask;
			if (out_go)
				st.pin_word <= st.xfer;
		end
	end

	// A write arriving with the pin update re-arms the output
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			st.pending <= 1'b0;
		else if (wr_data && cfg.out)
			st.pending <= 1'b1;
		else if (out_go)
			st.pending <= 1'b0;
	end

	// Capture wins over a read in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			st.valid <= 1'b0;
		else if (in_go)
			st.valid <= 1'b1;
		else if (rd_data)
			st.valid <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st.tstamp <= '0;
			st.ready  <= 1'b0;
			st.strobe <= 1'b0;
		end
		else
		begin
			st.ready  <= in_go | out_go;
			st.strobe <= out_go & cfg.stb;
			if (in_go || out_go)
				st.tstamp <= st.count;
		end
	end

endmodule

// ---- iop_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Five ports of 1, 4, 8, 16 and 32 bits share one pin bank.
// - All pins of a port face one direction, input or output.
// - A port drives its pins, or samples them, optionally waiting for a match.
// - Open collector: zero pulls low, one floats; chosen per port.
// - Data passes a pin register and a transfer register.
// - Each port has a readable 16-bit counter that can time transfers.
// - Each transfer saves the counter value as a timestamp.
// - An enabled serial link takes drive of its pins from the ports; input ports still sample them.
// - A narrower enabled port owns shared pins; other pins stay with wider.
// - Ports always transfer their full nominal width.
// - Six clock blocks; block 0 is the reference, others programmable.
// - A clock block may run from the 1-bit port pin, optionally divided.
// - Ports take an input strobe and may emit an output strobe.
// - After reset every port uses clock block 0.
// - Every core access completes in one cycle.
// - While reset is held every pin has its pull-down on.
module iop_top
	import iop_pkg::*;
(
	input  wire logic                   core_clk,   // 40 MHz core clock
	input  wire logic                   rst_n,      // Synchronous reset, active low
	input  wire logic [11:0]            paddr,      // APB address
	input  wire logic                   psel,       // APB select
	input  wire logic                   penable,    // APB enable
	input  wire logic                   pwrite,     // APB direction, high for write
	input  wire logic [31:0]            pwdata,     // APB write data
	output logic      [31:0]            prdata,     // APB read data
	output logic                        pready,     // APB ready
	output logic                        pslverr,    // APB error on unmapped address
	input  wire logic [IOP_NPIN-1:0]    pin_in,     // Pin levels
	output logic      [IOP_NPIN-1:0]    pin_out,    // Pin drive value
	output logic      [IOP_NPIN-1:0]    pin_oe,     // Pin drive enable
	output logic      [IOP_NPIN-1:0]    pin_pd_en,  // Pin pull-down enable
	input  wire logic [IOP_NPORT-1:0]   strobe_in,  // Strobes from external logic
	output logic      [IOP_NPORT-1:0]   strobe_out, // Strobes with output data
	output logic                        irq         // Unmasked ready event pending
);

	iop_word_t              pin_s1_ff;
	iop_word_t              pin_s2_ff;
	logic [IOP_NPORT-1:0]   stb_s1_ff;
	logic [IOP_NPORT-1:0]   stb_s2_ff;

	iop_word_t              ctrl_ff   [IOP_NPORT];
	iop_word_t              cond_ff   [IOP_NPORT];
	logic [IOP_CNT_W-1:0]   time_ff   [IOP_NPORT];
	iop_word_t              clkcfg_ff [IOP_NCLK];
	logic                   link_en_ff;
	logic [IOP_NPORT-1:0]   irq_stat_ff;
	logic [IOP_NPORT-1:0]   irq_mask_ff;

	iop_port_cfg_s          cfg       [IOP_NPORT];
	iop_port_st_s           st        [IOP_NPORT];
	iop_word_t              wmask     [IOP_NPORT];
	logic [IOP_NCLK-1:0]    clk_tick;
	logic [IOP_NPORT-1:0]   port_tick;
	logic [IOP_NPORT-1:0]   wr_data;
	logic [IOP_NPORT-1:0]   rd_data;
	logic [IOP_NPORT-1:0]   ready_ev;

	logic                   setup;
	logic                   wr_acc;
	logic                   rd_acc;
	logic                   port_hit;
	logic [2:0]             port_idx;
	logic [4:0]             port_ofs;
	logic                   nxt_err;
	iop_word_t              nxt_rdata;

	iop_word_t              nxt_pin_out;
	iop_word_t              nxt_pin_oe;
	iop_word_t              claimed;

	// Two flip-flops on every pin before any logic looks at it
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			stb_s1_ff <= '0;
			stb_s2_ff <= '0;
		end
		else
		begin
			pin_s1_ff <= pin_in;
			pin_s2_ff <= pin_s1_ff;
			stb_s1_ff <= strobe_in;
			stb_s2_ff <= stb_s1_ff;
		end
	end

	// APB: the answer comes in the first access cycle, no wait states
	assign setup    = psel & ~penable;
	assign wr_acc   = psel & penable & pready & pwrite;
	assign rd_acc   = psel & penable & pready & ~pwrite;
	assign port_hit = (paddr < (IOP_PORT_BASE + IOP_PORT_STRIDE * 12'(IOP_NPORT)));
	assign port_idx = paddr[7:5];
	assign port_ofs = paddr[4:0];

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			pready <= 1'b0;
		else
			pready <= setup & ~pready;
	end

	always_comb
	begin
		nxt_rdata = IOP_UNMAPPED;
		nxt_err   = 1'b0;
		if (port_hit)
		begin
			unique case (port_ofs)
				IOP_OFS_CTRL:   nxt_rdata = ctrl_ff[port_idx];
				IOP_OFS_DATA:   nxt_rdata = st[port_idx].xfer;
				IOP_OFS_COND:   nxt_rdata = cond_ff[port_idx];
				IOP_OFS_TIME:   nxt_rdata = {16'h0000, time_ff[port_idx]};
				IOP_OFS_COUNT:  nxt_rdata = {16'h0000, st[port_idx].count};
				IOP_OFS_TSTAMP: nxt_rdata = {16'h0000, st[port_idx].tstamp};
				IOP_OFS_STAT:   nxt_rdata = {30'h0000_0000, st[port_idx].pending,
				                             st[port_idx].valid};
				default:        nxt_err   = 1'b1;
			endcase
		end
		else if (paddr == IOP_LINK_EN)
			nxt_rdata = {31'h0000_0000, link_en_ff};
		else if (paddr == IOP_IRQ_STAT)
			nxt_rdata = {27'h000_0000, irq_stat_ff};
		else if (paddr == IOP_IRQ_MASK)
			nxt_rdata = {27'h000_0000, irq_mask_ff};
		else if (paddr >= IOP_CLK_BASE && paddr < IOP_CLK_BASE + 12'(4 * IOP_NCLK)
		         && paddr[1:0] == 2'b00)
			nxt_rdata = clkcfg_ff[3'(paddr[4:2])];
		else
			nxt_err = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata  <= pwrite ? '0 : nxt_rdata;
			pslverr <= nxt_err;
		end
		else
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
	end

	// Global registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			link_en_ff  <= 1'b0;
			irq_mask_ff <= IOP_MASK_RST[IOP_NPORT-1:0];
		end
		else if (wr_acc && !pslverr)
		begin
			if (paddr == IOP_LINK_EN)
				link_en_ff <= pwdata[0];
			if (paddr == IOP_IRQ_MASK)
				irq_mask_ff <= pwdata[IOP_NPORT-1:0];
		end
	end

	// A new event in the clearing read cycle stays set
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			irq_stat_ff <= '0;
		else if (rd_acc && paddr == IOP_IRQ_STAT)
			irq_stat_ff <= ready_ev;
		else
			irq_stat_ff <= irq_stat_ff | ready_ev;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |((irq_stat_ff | ready_ev) & irq_mask_ff);
	end

	// Clock blocks; block 0 is tied to the reference source
	genvar k;
	generate
		for (k = 0; k < IOP_NCLK; k++)
		begin : g_clk
			always_ff @(posedge core_clk)
			begin
				if (!rst_n)
					clkcfg_ff[k] <= IOP_CLKCFG_RST;
				else if (wr_acc && k != 0 && paddr == IOP_CLK_BASE + 12'(4 * k))
					clkcfg_ff[k] <= pwdata;
			end

			iop_clk_blk u_clk (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.ext_sel  (clkcfg_ff[k][IOP_CK_EXT]),
				.div      (clkcfg_ff[k][IOP_CK_DIV_LSB +: IOP_DIV_W]),
				.ext_lvl  (pin_s2_ff[0]),
				.tick     (clk_tick[k])
			);
		end
	endgenerate

	// Ports
	genvar p;
	generate
		for (p = 0; p < IOP_NPORT; p++)
		begin : g_port
			localparam logic [11:0] BASE = IOP_PORT_BASE + IOP_PORT_STRIDE * 12'(p);

			assign wmask[p] = iop_word_t'((64'h1 << IOP_PORT_W[p]) - 64'h1);

			always_ff @(posedge core_clk)
			begin
				if (!rst_n)
				begin
					ctrl_ff[p] <= IOP_CTRL_RST;
					cond_ff[p] <= '0;
					time_ff[p] <= '0;
				end
				else if (wr_acc)
				begin
					if (paddr == BASE + 12'(IOP_OFS_CTRL))
						ctrl_ff[p] <= pwdata & 32'h0000_07FF;
					if (paddr == BASE + 12'(IOP_OFS_COND))
						cond_ff[p] <= pwdata & wmask[p];
					if (paddr == BASE + 12'(IOP_OFS_TIME))
						time_ff[p] <= pwdata[IOP_CNT_W-1:0];
				end
			end

			assign wr_data[p] = wr_acc & (paddr == BASE + 12'(IOP_OFS_DATA));
			assign rd_data[p] = rd_acc & (paddr == BASE + 12'(IOP_OFS_DATA));

			always_comb
			begin
				cfg[p].en       = ctrl_ff[p][IOP_CTL_EN];
				cfg[p].out      = ctrl_ff[p][IOP_CTL_OUT];
				cfg[p].oc       = ctrl_ff[p][IOP_CTL_OC];
				cfg[p].cond     = ctrl_ff[p][IOP_CTL_COND];
				cfg[p].cond_neq = ctrl_ff[p][IOP_CTL_NEQ];
				cfg[p].timed    = ctrl_ff[p][IOP_CTL_TIMED];
				cfg[p].stb      = ctrl_ff[p][IOP_CTL_STB];
				cfg[p].clk_sel  = ctrl_ff[p][IOP_CTL_CLK_LSB +: 3];
				cfg[p].cond_val = cond_ff[p];
				cfg[p].time_val = time_ff[p];
			end

			// Selection codes beyond the last block fall back to block 0
			assign port_tick[p] = (cfg[p].clk_sel < 3'(IOP_NCLK)) ?
				clk_tick[cfg[p].clk_sel] : clk_tick[0];

			iop_port_unit u_port (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.cfg      (cfg[p]),
				.wmask    (wmask[p]),
				.tick     (port_tick[p]),
				.pins     (pin_s2_ff),
				.stb_in   (stb_s2_ff[p]),
				.wr_data  (wr_data[p]),
				.wdata    (pwdata),
				.rd_data  (rd_data[p]),
				.st       (st[p])
			);

			assign ready_ev[p] = st[p].ready;

			always_ff @(posedge core_clk)
			begin
				if (!rst_n)
					strobe_out[p] <= 1'b0;
				else
					strobe_out[p] <= st[p].strobe;
			end
		end
	endgenerate

	// Pin ownership: narrowest enabled port wins, the link beats all
	always_comb
	begin
		nxt_pin_out = '0;
		nxt_pin_oe  = '0;
		claimed     = '0;
		for (int i = 0; i < IOP_NPIN; i++)
		begin
			for (int q = IOP_NPORT - 1; q >= 0; q--)
			begin
				if (cfg[q].en && wmask[q][i])
				begin
					claimed[i] = 1'b1;
					if (cfg[q].out)
					begin
						nxt_pin_out[i] = cfg[q].oc ? 1'b0 : st[q].pin_word[i];
						nxt_pin_oe[i]  = cfg[q].oc ? ~st[q].pin_word[i] : 1'b1;
					end
					else
					begin
						nxt_pin_out[i] = 1'b0;
						nxt_pin_oe[i]  = 1'b0;
					end
				end
			end
			if (link_en_ff && IOP_LINK_PINS[i])
			begin
				claimed[i]     = 1'b1;
				nxt_pin_out[i] = 1'b0;
				nxt_pin_oe[i]  = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pin_out   <= '0;
			pin_oe    <= '0;
			pin_pd_en <= '1;
		end
		else
		begin
			pin_out   <= nxt_pin_out;
			pin_oe    <= nxt_pin_oe;
			pin_pd_en <= ~claimed;
		end
	end

endmodule

// ---- iop_top_asserts.sv ----
`timescale 1ns/1ps
module iop_top_asserts
	import iop_pkg::*;
(
	input	wire logic			core_clk,	// Clock
	input	wire logic			rst_n,		// Reset
	input	wire logic [11:0]		paddr,		// Address
	input	wire logic			psel,		// Select
	input	wire logic			penable,	// Enable
	input	wire logic [31:0]		prdata,		// Read data
	input	wire logic			pready,		// Ready
	input	wire logic			pslverr,	// Error
	input	wire logic [IOP_NPIN-1:0]	pin_oe,		// Drive enable
	input	wire logic [IOP_NPIN-1:0]	pin_pd_en,	// Pull-down
	input	wire logic [IOP_NPORT-1:0]	strobe_out,	// Strobes
	input	wire logic			irq		// Interrupt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Cycles since the last access that may lower irq, saturating
	logic [3:0]	irq_age_ff;
	logic [3:0]	nxt_irq_age;

	always_comb
	begin
		nxt_irq_age = irq_age_ff + ((irq_age_ff != 4'hF) ? 4'h1 : 4'h0);
		if (pready && (paddr == IOP_IRQ_STAT || paddr == IOP_IRQ_MASK))
			nxt_irq_age = 4'h0;
	end

	always_ff @(posedge core_clk)
		irq_age_ff <= rst_n ? nxt_irq_age : 4'hF;

	AST_RST_SAFE: assert property ($rose(rst_n) |-> &pin_pd_en && pin_oe == '0 && !irq)
		else $error("pins not safe at reset release");
	AST_APB_ONE: assert property (psel && !penable |=> pready)
		else $error("access not done in one cycle");
	AST_RDY_PULSE: assert property (pready |-> psel && penable ##1 !pready)
		else $error("ready outside access or longer than one cycle");
	AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == '0)
		else $error("error without ready or with data");
	AST_IDLE_ZERO: assert property (!pready |-> prdata == '0 && !pslverr)
		else $error("read data outside access");
	AST_PD_DRIVEN: assert property ((pin_pd_en & pin_oe) == '0)
		else $error("pull-down on a driven pin");
	AST_STB_ONE: assert property ((strobe_out & $past(strobe_out)) == '0)
		else $error("output strobe longer than one cycle");
	AST_IRQ_DROP: assert property ($fell(irq) |-> irq_age_ff <= 4'h3)
		else $error("irq fell without status read or mask");

	cover property ($rose(irq));
	cover property (pslverr);
	cover property (strobe_out != '0);
	cover property (pin_oe != '0 && pin_pd_en != '0);
endmodule

// ---- iop_ext_model.sv ----
`timescale 1ns/1ps
module iop_ext_model
	import iop_pkg::*;
(
	input	wire logic			core_clk,	// Paces the model
	input	wire logic [IOP_NPIN-1:0]	pin_out,	// Device drive value
	input	wire logic [IOP_NPIN-1:0]	pin_oe,		// Device drive enable
	input	wire logic [IOP_NPIN-1:0]	pin_pd_en,	// Device pull-down
	output	logic [IOP_NPIN-1:0]		pin_in,		// Resolved levels
	output	logic [IOP_NPORT-1:0]		strobe_in	// Strobes to device
);
	iop_word_t	ext_val;
	iop_word_t	ext_en;
	logic		flip;

	initial
	begin
		ext_val = '0;
		ext_en = '0;
		strobe_in = '0;
		flip = 1'b0;
	end

	// A floating pin toggles so a stale level can never pass as data
	always @(posedge core_clk)
		flip <= ~flip;

	always_comb
		for (int i = 0; i < IOP_NPIN; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : !pin_pd_en[i] & flip;

	task automatic present(input iop_word_t val, input iop_word_t en, input logic [4:0] stb);
		@(posedge core_clk);
		ext_val <= val;
		ext_en <= en;
		strobe_in <= stb;
	endtask

	// Clock on pin 0 runs only while asked for
	task automatic clock_pin0(input int edges, input int half);
		repeat (edges)
		begin
			repeat (half) @(posedge core_clk);
			ext_val[0] <= 1'b1;
			repeat (half) @(posedge core_clk);
			ext_val[0] <= 1'b0;
		end
	endtask
endmodule

// ---- tb_iop.sv ----
`timescale 1ns/1ps
module tb
	import iop_pkg::*;
;
	logic			core_clk;
	logic			rst_n;
	logic [11:0]		paddr;
	logic			psel;
	logic			penable;
	logic			pwrite;
	iop_word_t		pwdata;
	iop_word_t		prdata;
	logic			pready;
	logic			pslverr;
	iop_word_t		pin_in;
	iop_word_t		pin_out;
	iop_word_t		pin_oe;
	iop_word_t		pin_pd_en;
	logic [IOP_NPORT-1:0]	strobe_in;
	logic [IOP_NPORT-1:0]	strobe_out;
	logic			irq;
	int			err_total;
	int			checked;
	int			cycles;
	iop_word_t		q;
	logic			e;

	iop_top dut (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pd_en, .strobe_in,
		.strobe_out, .irq);
	iop_ext_model ext (.core_clk, .pin_out, .pin_oe, .pin_pd_en, .pin_in, .strobe_in);

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic tally_and_finish;
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic check(input string what, input iop_word_t exp, input iop_word_t got);
		checked++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask

	function automatic logic [11:0] preg(input int p, input logic [4:0] ofs);
		return IOP_PORT_BASE + 12'(p) * IOP_PORT_STRIDE + 12'(ofs);
	endfunction

	task automatic apb(input logic wr, input logic [11:0] a, input iop_word_t d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n == 16)
		begin
			err_total++;
			tally_and_finish();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input iop_word_t d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input string what, input logic [11:0] a, input iop_word_t exp);
		apb(1'b0, a, '0);
		check(what, exp, q);
	endtask

	// Levels are judged only on pins expected to be driven
	task automatic settle(input string what, input iop_word_t m, input iop_word_t oe,
		input iop_word_t lvl);
		int n;
		for (n = 0; n < 12 && ((pin_oe & m) !== oe || (pin_in & oe) !== lvl); n++)
			@(posedge core_clk);
		check(what, oe, pin_oe & m);
		check(what, lvl, pin_in & oe);
	endtask

	task automatic wait_irq(input logic lvl);
		int n;
		for (n = 0; n < 100 && irq !== lvl; n++)
			@(posedge core_clk);
		check("irq", {31'h0, lvl}, {31'h0, irq});
	endtask

	task automatic offer(input logic [4:0] stb);
		ext.present(32'h0000_1234, 32'h0000_FFFF, stb);
		repeat (3) @(posedge core_clk);
		ext.present(32'h0, 32'h0000_FFFF, 5'h00);
		repeat (6) @(posedge core_clk);
	endtask

	task automatic t_regs;
		rd("ctrl rst", preg(2, IOP_OFS_CTRL), IOP_CTRL_RST);
		rd("clk rst", IOP_CLK_BASE + 12'h004, IOP_CLKCFG_RST);
		rd("mask rst", IOP_IRQ_MASK, IOP_MASK_RST);
		wr(IOP_CLK_BASE, 32'h0000_0101);
		rd("clk0", IOP_CLK_BASE, IOP_CLKCFG_RST);
		wr(IOP_CLK_BASE + 12'h014, 32'h0000_0301);
		rd("clk5", IOP_CLK_BASE + 12'h014, 32'h0000_0301);
		check("clk5 err", 32'h0, {31'h0, e});
		rd("unmapped", IOP_CLK_BASE + 12'h018, IOP_UNMAPPED);
		check("unmapped err", 32'h1, {31'h0, e});
	endtask

	task automatic t_extclk;
		iop_word_t c0;
		ext.present(32'h0, 32'h1, 5'h00);
		wr(IOP_CLK_BASE + 12'h004, 32'h0000_0101);
		wr(preg(3, IOP_OFS_CTRL), 32'h0000_0101);
		apb(1'b0, preg(3, IOP_OFS_COUNT), '0);
		c0 = q;
		ext.clock_pin0(8, 3);
		repeat (6) @(posedge core_clk);
		rd("ext ticks", preg(3, IOP_OFS_COUNT), (c0 + 32'h4) & 32'hFFFF);
		wr(preg(3, IOP_OFS_CTRL), 32'h0);
		rd("ext events", IOP_IRQ_STAT, 32'h8);
	endtask

	task automatic t_timed;
		iop_word_t c0;
		wr(preg(0, IOP_OFS_CTRL), 32'h0000_0020);
		apb(1'b0, preg(0, IOP_OFS_COUNT), '0);
		c0 = q;
		rd("count step", preg(0, IOP_OFS_COUNT), (c0 + 32'h3) & 32'hFFFF);
		wr(preg(0, IOP_OFS_TIME), (c0 + 32'h40) & 32'hFFFF);
		wr(IOP_IRQ_MASK, 32'h1);
		wr(preg(0, IOP_OFS_CTRL), 32'h0000_0021);
		wait_irq(1'b1);
		rd("tstamp", preg(0, IOP_OFS_TSTAMP), (c0 + 32'h40) & 32'hFFFF);
		rd("timed stat", IOP_IRQ_STAT, 32'h1);
		wr(preg(0, IOP_OFS_CTRL), 32'h0);
	endtask

	task automatic t_output;
		int n;
		wr(preg(1, IOP_OFS_CTRL), 32'h0000_0043);
		wr(preg(1, IOP_OFS_DATA), 32'hFFFF_FF5A);
		n = 0;
		repeat (10)
		begin
			@(posedge core_clk);
			if (strobe_out[1] === 1'b1)
				n++;
		end
		check("strobe", 32'h1, 32'(n));
		settle("port1", '1, 32'h0000_000F, 32'h0000_000A);
		wr(preg(2, IOP_OFS_CTRL), 32'h0000_0007);
		wr(preg(2, IOP_OFS_DATA), 32'h0000_005A);
		settle("shared", 32'hFF, 32'h0000_00AF, 32'h0000_000A);
		wr(preg(1, IOP_OFS_CTRL), 32'h0);
		settle("oc", 32'hFF, 32'h0000_00A5, 32'h0);
		wr(preg(2, IOP_OFS_CTRL), 32'h0);
		rd("out events", IOP_IRQ_STAT, 32'h6);
	endtask

	task automatic t_input;
		wr(IOP_IRQ_MASK, 32'h0);
		wr(preg(3, IOP_OFS_COND), 32'h0000_1234);
		wr(preg(3, IOP_OFS_CTRL), 32'h0000_0049);
		apb(1'b0, preg(3, IOP_OFS_DATA), '0);
		offer(5'h00);
		rd("no strobe", preg(3, IOP_OFS_STAT), 32'h0);
		offer(5'h08);
		check("masked irq", 32'h0, {31'h0, irq});
		rd("event", IOP_IRQ_STAT, 32'h8);
		rd("read clear", IOP_IRQ_STAT, 32'h0);
		rd("data", preg(3, IOP_OFS_DATA), 32'h0000_1234);
		rd("valid clr", preg(3, IOP_OFS_STAT), 32'h0);
		wr(IOP_IRQ_MASK, 32'h8);
		offer(5'h08);
		wait_irq(1'b1);
		rd("irq src", IOP_IRQ_STAT, 32'h8);
		wait_irq(1'b0);
	endtask

	task automatic t_link;
		wr(preg(4, IOP_OFS_CTRL), 32'h0000_0003);
		wr(preg(4, IOP_OFS_DATA), 32'hFFFF_FFFF);
		settle("wide", '1, 32'hFFFF_0000, 32'hFFFF_0000);
		wr(IOP_LINK_EN, 32'h1);
		settle("link", '1, 32'h00FF_0000, 32'h00FF_0000);
		wr(IOP_LINK_EN, 32'h0);
		settle("unlink", '1, 32'hFFFF_0000, 32'hFFFF_0000);
	endtask

	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		err_total = 0;
		checked = 0;
		cycles = 0;
		repeat (6) @(posedge core_clk);
		check("pd in reset", '1, pin_pd_en);
		check("oe in reset", '0, pin_oe);
		rst_n <= 1'b1;
		t_regs();
		t_extclk();
		t_timed();
		t_output();
		t_input();
		t_link();
		tally_and_finish();
	end
endmodule

bind iop_top iop_top_asserts chk (.core_clk, .rst_n, .paddr, .psel, .penable, .prdata,
	.pready, .pslverr, .pin_oe, .pin_pd_en, .strobe_out, .irq);
